//--- include/ocmc_map.svh
// register map, field positions, reset values and level codes of the output mute control
//
// What this block does
// RULE_01 - two-bit chan4 silenced level, resets to one
// RULE_02 - level picks drive state, enable decides mute
// RULE_03 - software should program chan4 level to three
// RULE_04 - diff: bypass, powerdown to common-mode, force high
// RULE_05 - diff code three: positive to rail, negative ground
// RULE_06 - cmos: bypass, n low, p low, both low
// RULE_07 - eight-bit mute enable register, all ones reset
// RULE_08 - enabled channel disabled while selected source invalid
// RULE_09 - disabled bit keeps channel running regardless
// RULE_10 - muted channel resumes when source valid again
`ifndef OCMC_MAP_SVH
`define OCMC_MAP_SVH

// -----------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define OCMC_IDX_LEVEL 8'h15
`define OCMC_IDX_MUTE_EN 8'h16
`define OCMC_IDX_CTRL 8'h20
`define OCMC_IDX_STATUS 8'h21

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define OCMC_LVL_LSB 0
`define OCMC_LVL_MSB 1
`define OCMC_CTRL_CMOS_BIT 0
`define OCMC_STAT_VALID_BIT 0
`define OCMC_STAT_SIL_LSB 8
`define OCMC_STAT_SIL_MSB 15

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define OCMC_RST_MUTE_EN 8'hff
`define OCMC_RST_LEVEL 2'h1
`define OCMC_RST_CMOS 1'h0
`define OCMC_RECOMMENDED_LEVEL 2'h3

// -----------------------------------------------------------------
// silenced level codes
// -----------------------------------------------------------------
`define OCMC_LVL_BYPASS 2'h0
`define OCMC_LVL_CODE1 2'h1
`define OCMC_LVL_CODE2 2'h2
`define OCMC_LVL_CODE3 2'h3

// -----------------------------------------------------------------
// bus constants
// -----------------------------------------------------------------
`define OCMC_HTRANS_NONSEQ 2'h2
`define OCMC_HTRANS_SEQ 2'h3
`define OCMC_HSIZE_WORD 3'h2

`endif

//--- include/ocmc_pkg.sv
// types shared by the output mute control design files
`default_nettype none

package ocmc_pkg;

  // output driver mode of channel 4
  typedef enum logic {
    OCMC_MODE_DIFF,
    OCMC_MODE_CMOS
  } ocmc_mode_t;

  // channel 4 driver controls; all zero means normal operation
  typedef struct packed {
    logic diff_pwrdn;
    logic diff_force_hi;
    logic diff_rail_split;
    logic cmos_p_low;
    logic cmos_n_low;
  } ocmc_drv_t;

  // captured address phase of an ahb transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] idx;
  } ocmc_req_t;

endpackage

`default_nettype wire

//--- rtl/ocmc_chan4_drive.sv
// channel 4 silenced drive decoder
`timescale 1ns/100ps
`default_nettype none
`include "ocmc_map.svh"

module ocmc_chan4_drive (
  // mute state
  input wire logic silenced,
  input wire ocmc_pkg::ocmc_mode_t mode,
  input wire logic [1:0] level,
  // driver controls
  output ocmc_pkg::ocmc_drv_t drv
);

  always_comb begin
    drv = '0;
    // level only shapes the driver; it never starts a mute on its own
    if (silenced) begin // RULE_02
      if (mode == ocmc_pkg::OCMC_MODE_DIFF) begin
        case (level) // RULE_04
          `OCMC_LVL_BYPASS: drv = '0;
          `OCMC_LVL_CODE1: drv.diff_pwrdn = 1'b1;
          `OCMC_LVL_CODE2: drv.diff_force_hi = 1'b1;
          `OCMC_LVL_CODE3: drv.diff_rail_split = 1'b1; // RULE_05
          default: drv = '0;
        endcase
      end else begin
        case (level) // RULE_06
          `OCMC_LVL_BYPASS: drv = '0;
          `OCMC_LVL_CODE1: drv.cmos_n_low = 1'b1;
          `OCMC_LVL_CODE2: drv.cmos_p_low = 1'b1;
          `OCMC_LVL_CODE3: begin
            drv.cmos_p_low = 1'b1;
            drv.cmos_n_low = 1'b1;
          end
          default: drv = '0;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

//--- rtl/ocmc_top.sv
// output channel mute control: ahb-lite registers, source sync and mute outputs
`timescale 1ns/100ps
`default_nettype none
`include "ocmc_map.svh"

module ocmc_top #(
  parameter int NUM_CHAN = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // selected input clock source validity from the detector
  input wire logic src_valid,
  // per-channel mute outputs, one means the channel is disabled
  output logic [NUM_CHAN-1:0] chan_silenced,
  // channel 4 driver controls while silenced
  output ocmc_pkg::ocmc_drv_t chan4_drv
);

  // -----------------------------------------------------------------
  // source validity synchroniser
  // -----------------------------------------------------------------
  logic sv_meta_ff;
  logic sv_sync_ff;
  logic nxt_sv_meta;
  logic nxt_sv_sync;

  // the detector may run from another clock, so two stages before use
  always_comb begin
    nxt_sv_meta = src_valid;
    nxt_sv_sync = sv_meta_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sv_meta_ff <= 1'b0;
      sv_sync_ff <= 1'b0;
    end else begin
      sv_meta_ff <= nxt_sv_meta;
      sv_sync_ff <= nxt_sv_sync;
    end
  end

  // -----------------------------------------------------------------
  // ahb-lite address phase capture
  // -----------------------------------------------------------------
  ocmc_pkg::ocmc_req_t req_ff;
  ocmc_pkg::ocmc_req_t nxt_req;
  logic addr_take;
  logic addr_hit;

  // only whole-word accesses inside the low 1 KB window are decoded
  assign addr_hit = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00) && (hsize == `OCMC_HSIZE_WORD);
  assign addr_take = hsel && hready && ((htrans == `OCMC_HTRANS_NONSEQ) || (htrans == `OCMC_HTRANS_SEQ));

  always_comb begin
    nxt_req = req_ff;
    if (hready) begin
      nxt_req.valid = addr_take && addr_hit;
      nxt_req.write = hwrite;
      nxt_req.idx = haddr[9:2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ff <= '0;
    end else begin
      req_ff <= nxt_req;
    end
  end

  // -----------------------------------------------------------------
  // register index decode
  // -----------------------------------------------------------------
  localparam int SEL_LEVEL = 0;
  localparam int SEL_MUTE_EN = 1;
  localparam int SEL_CTRL = 2;
  localparam int SEL_STATUS = 3;

  // one decoder for both paths, so a write and a read of one index can
  // never disagree about which register they reach
  function automatic logic [3:0] reg_sel(input logic [7:0] idx);
    logic [3:0] sel;
    sel = 4'h0;
    case (idx)
      `OCMC_IDX_LEVEL: sel[SEL_LEVEL] = 1'b1;
      `OCMC_IDX_MUTE_EN: sel[SEL_MUTE_EN] = 1'b1;
      `OCMC_IDX_CTRL: sel[SEL_CTRL] = 1'b1;
      `OCMC_IDX_STATUS: sel[SEL_STATUS] = 1'b1;
      default: sel = 4'h0;
    endcase
    return sel;
  endfunction

  // -----------------------------------------------------------------
  // control registers
  // -----------------------------------------------------------------
  logic [NUM_CHAN-1:0] mute_en_ff;
  logic [1:0] level_ff;
  ocmc_pkg::ocmc_mode_t mode_ff;
  logic [NUM_CHAN-1:0] nxt_mute_en;
  logic [1:0] nxt_level;
  ocmc_pkg::ocmc_mode_t nxt_mode;
  logic wr_commit;
  logic [3:0] wr_sel;

  // writes land at the end of the data phase; the slave never stalls
  assign wr_commit = req_ff.valid && req_ff.write;
  assign wr_sel = reg_sel(req_ff.idx);

  // status is read-only: a write to its index changes nothing
  always_comb begin
    nxt_mute_en = mute_en_ff;
    nxt_level = level_ff;
    nxt_mode = mode_ff;
    if (wr_commit && wr_sel[SEL_MUTE_EN]) begin
      nxt_mute_en = hwdata[NUM_CHAN-1:0]; // RULE_07
    end
    if (wr_commit && wr_sel[SEL_LEVEL]) begin
      nxt_level = hwdata[`OCMC_LVL_MSB:`OCMC_LVL_LSB]; // RULE_01
    end
    if (wr_commit && wr_sel[SEL_CTRL]) begin
      nxt_mode = hwdata[`OCMC_CTRL_CMOS_BIT] ? ocmc_pkg::OCMC_MODE_CMOS : ocmc_pkg::OCMC_MODE_DIFF;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mute_en_ff <= NUM_CHAN'(`OCMC_RST_MUTE_EN); // RULE_07
      level_ff <= `OCMC_RST_LEVEL; // RULE_01
      mode_ff <= ocmc_pkg::OCMC_MODE_DIFF;
    end else begin
      mute_en_ff <= nxt_mute_en;
      level_ff <= nxt_level;
      mode_ff <= nxt_mode;
    end
  end

  // -----------------------------------------------------------------
  // mute decision per channel
  // -----------------------------------------------------------------
  logic [NUM_CHAN-1:0] nxt_silenced;

  // purely combinational on the synced validity: a channel comes back on
  // its own as soon as the source is reported good again
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    assign nxt_silenced[ch] = mute_en_ff[ch] && !sv_sync_ff; // RULE_08 RULE_09 RULE_10
  end

  // -----------------------------------------------------------------
  // channel 4 driver decode
  // -----------------------------------------------------------------
  ocmc_pkg::ocmc_drv_t nxt_chan4_drv;

  ocmc_chan4_drive u_chan4_drive (
    .silenced(nxt_silenced[4]),
    .mode(mode_ff),
    .level(level_ff),
    .drv(nxt_chan4_drv)
  );

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  logic [31:0] nxt_hrdata;
  logic [31:0] rd_word;
  logic [3:0] rd_sel;

  assign rd_sel = reg_sel(haddr[9:2]);

  // reads sample the next-state values so a read straight after a write
  // to the same register already returns the new contents
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_sel[SEL_MUTE_EN]) begin
      rd_word[NUM_CHAN-1:0] = nxt_mute_en;
    end
    if (rd_sel[SEL_LEVEL]) begin
      rd_word[`OCMC_LVL_MSB:`OCMC_LVL_LSB] = nxt_level;
    end
    if (rd_sel[SEL_CTRL]) begin
      rd_word[`OCMC_CTRL_CMOS_BIT] = (nxt_mode == ocmc_pkg::OCMC_MODE_CMOS);
    end
    if (rd_sel[SEL_STATUS]) begin
      rd_word[`OCMC_STAT_VALID_BIT] = sv_sync_ff;
      rd_word[`OCMC_STAT_SIL_MSB:`OCMC_STAT_SIL_LSB] = chan_silenced;
    end
  end

  always_comb begin
    nxt_hrdata = hrdata;
    if (hready) begin
      nxt_hrdata = (addr_take && addr_hit && !hwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // -----------------------------------------------------------------
  // bus response
  // -----------------------------------------------------------------
  logic nxt_hreadyout;
  logic nxt_hresp;

  // zero wait states and never an error: unmapped or odd-sized accesses
  // still complete okay, so a stray access cannot hang the bus
  always_comb begin
    nxt_hreadyout = 1'b1;
    nxt_hresp = 1'b0;
  end

  // -----------------------------------------------------------------
  // output registers
  // -----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      chan_silenced <= '0;
      chan4_drv <= '0;
    end else begin
      hrdata <= nxt_hrdata;
      hreadyout <= nxt_hreadyout;
      hresp <= nxt_hresp;
      chan_silenced <= nxt_silenced; // RULE_08 RULE_09
      chan4_drv <= nxt_chan4_drv; // RULE_02
    end
  end

endmodule

`default_nettype wire

//--- tb/ocmc_src_model.sv
// source validity model standing in for the clock detector
`timescale 1ns/100ps
`default_nettype none

module ocmc_src_model (
  // clock
  input wire logic hclk,
  // verdict requested by the bench
  input wire logic want,
  // validity seen by the block
  output logic src_valid
);
  // the detector only revises its verdict on a clock edge
  always_ff @(posedge hclk) begin
    src_valid <= want;
  end
endmodule

`default_nettype wire

//--- tb/ocmc_asserts.sv
// concurrent checks on the mute control ports
`timescale 1ns/100ps
`default_nettype none
`include "ocmc_map.svh"

module ocmc_asserts #(
  parameter int NUM_CHAN = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // source and outputs
  input wire logic src_valid,
  input wire logic [NUM_CHAN-1:0] chan_silenced,
  input wire ocmc_pkg::ocmc_drv_t chan4_drv
);
  // ----------------------------------------------------------
  // register shadow, the slave never stalls
  // ----------------------------------------------------------
  logic pend_ff, wr_ff, md_ff, nxt_pend, nxt_wr, nxt_md;
  logic [7:0] idx_ff, en_ff, nxt_idx, nxt_en;
  logic [1:0] lvl_ff, nxt_lvl;
  always_comb begin
    nxt_pend = htrans[1];
    nxt_wr = hwrite;
    nxt_idx = haddr[9:2];
    nxt_en = en_ff;
    nxt_lvl = lvl_ff;
    nxt_md = md_ff;
    if (pend_ff && wr_ff) begin
      if (idx_ff == `OCMC_IDX_MUTE_EN) nxt_en = hwdata[7:0];
      if (idx_ff == `OCMC_IDX_LEVEL) nxt_lvl = hwdata[1:0];
      if (idx_ff == `OCMC_IDX_CTRL) nxt_md = hwdata[0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_ff <= 1'b0;
      wr_ff <= 1'b0;
      idx_ff <= 8'h00;
      en_ff <= `OCMC_RST_MUTE_EN;
      lvl_ff <= `OCMC_RST_LEVEL;
      md_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      wr_ff <= nxt_wr;
      idx_ff <= nxt_idx;
      en_ff <= nxt_en;
      lvl_ff <= nxt_lvl;
      md_ff <= nxt_md;
    end
  end
  function automatic logic [4:0] drv_exp(input logic s, input logic m, input logic [1:0] c);
    return !s ? 5'h00 : m ? {3'h0, c} : {c == 2'h1, c == 2'h2, c == 2'h3, 2'h0};
  endfunction
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence src_lo3;
    (!src_valid)[*3];
  endsequence
  sequence src_hi3;
    src_valid[*3];
  endsequence
  a_mute_follows_en: assert property (src_lo3 ##1 $stable(en_ff) |-> chan_silenced == en_ff)
    else $error("mute mask wrong");
  a_valid_unmutes: assert property (src_hi3 |=> chan_silenced == '0)
    else $error("channel stays muted");
  a_clear_runs: assert property ($stable(en_ff) |-> (chan_silenced & ~en_ff) == 8'h00)
    else $error("disabled bit muted");
  a_fell_unmutes: assert property ($fell(en_ff[4]) |=> !chan_silenced[4])
    else $error("chan4 stays muted");
  a_drive_decode: assert property ($stable(lvl_ff) && $stable(md_ff) |->
    chan4_drv == drv_exp(chan_silenced[4], md_ff, lvl_ff))
    else $error("chan4 drive wrong");
  a_rd_mute_en: assert property (pend_ff && !wr_ff && idx_ff == `OCMC_IDX_MUTE_EN |-> hrdata == {24'h0, en_ff})
    else $error("mute read wrong");
  a_rd_level: assert property (pend_ff && !wr_ff && idx_ff == `OCMC_IDX_LEVEL |-> hrdata == {30'h0, lvl_ff})
    else $error("level read wrong");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not okay");
endmodule

bind ocmc_top ocmc_asserts #(.NUM_CHAN(NUM_CHAN)) u_chk (.hclk(hclk), .hresetn(hresetn), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .src_valid(src_valid), .chan_silenced(chan_silenced), .chan4_drv(chan4_drv));

`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the output mute control
`timescale 1ns/100ps
`default_nettype none
`include "ocmc_map.svh"

module tb;
  logic hclk, hresetn, hwrite, want, hrdy, hresp, src_valid;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] sil;
  ocmc_pkg::ocmc_drv_t drv;
  int fails, check_count;

  ocmc_top #(.NUM_CHAN(8)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(`OCMC_HSIZE_WORD), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .src_valid(src_valid), .chan_silenced(sil),
    .chan4_drv(drv));
  ocmc_src_model i_src (.hclk(hclk), .want(want), .src_valid(src_valid));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic [4:0] exp_drv(input logic s, input logic m, input logic [1:0] c);
    return !s ? 5'h00 : m ? {3'h0, c} : {c == 2'h1, c == 2'h2, c == 2'h3, 2'h0};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    htrans <= `OCMC_HTRANS_NONSEQ;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // ----------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    #100000;
    fails++;
    close_out();
  end
  initial begin
    logic [31:0] rd;
    logic [7:0] en;
    logic sv, md;
    hresetn = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    want = 1'b0;
    void'($urandom(32'h6c3d));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, `OCMC_IDX_MUTE_EN, 32'h0, rd);
    check(rd, 32'h0000_00ff);
    xfer(1'b0, `OCMC_IDX_LEVEL, 32'h0, rd);
    check(rd, 32'h0000_0001);
    xfer(1'b1, 8'h17, 32'hffff_ffff, rd);
    xfer(1'b0, 8'h17, 32'h0, rd);
    check(rd, 32'h0);
    // first eight pass every code with the source bad, then good, then random
    for (int i = 0; i < 24; i++) begin
      en = 8'($urandom);
      md = i[2];
      sv = i < 8 ? 1'b0 : i < 16 ? 1'b1 : 1'($urandom);
      want <= sv;
      xfer(1'b1, `OCMC_IDX_MUTE_EN, {24'h0, en}, rd);
      xfer(1'b1, `OCMC_IDX_LEVEL, {30'h0, i[1:0]}, rd);
      xfer(1'b1, `OCMC_IDX_CTRL, {31'h0, md}, rd);
      xfer(1'b0, `OCMC_IDX_MUTE_EN, 32'h0, rd);
      check(rd, {24'h0, en});
      repeat (6) @(posedge hclk);
      @(negedge hclk);
      check(32'(sil), sv ? 32'h0 : {24'h0, en});
      check(32'(drv), 32'(exp_drv(!sv && en[4], md, i[1:0])));
      xfer(1'b0, `OCMC_IDX_STATUS, 32'h0, rd);
      check(rd, {16'h0, (sv ? 8'h00 : en), 7'h0, sv});
      xfer(1'b0, `OCMC_IDX_CTRL, 32'h0, rd);
      check(rd, {31'h0, md});
    end
    close_out();
  end
endmodule

`default_nettype wire
